//--- core/monitor_entry_regs.vh
`ifndef MONITOR_ENTRY_REGS_VH
`define MONITOR_ENTRY_REGS_VH
// ==========================================================================
// Register map of the monitor control slave.
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h1
`define ADDR_RXDATA      4'h2
`define ADDR_TXDATA      4'h3
`define ADDR_SECKEY_LO   4'h4
`define ADDR_SECKEY_HI   4'h5
`define ADDR_VECTOR      4'h6
// ==========================================================================
// Field positions.
`define CTRL_TX_BREAK    0
`define STAT_MONITOR     0
`define STAT_FORCED      1
`define STAT_WDOG_OFF    2
`define STAT_SEC_DONE    3
`define STAT_SEC_OK      4
`define STAT_READY       5
`define STAT_RX_VALID    6
`define STAT_EXTRA_RST   7
`define STAT_DIV_SHIFT   8
// ==========================================================================
// Values and timing counts.
`define VECTOR_BLANK     16'hffff
`define BAUD_DIVISOR     278
`define SEC_BYTES        8
`define BREAK_BITS       10
`define DIV_BY_ONE       2'h0
`define DIV_BY_TWO       2'h1
`define DIV_BY_FOUR      2'h2
`define CLOCK_MHZ        40
`endif

//--- core/byte_fifo.v
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock,     // System clock.
  input  wire             nrst,      // Asynchronous reset, active low.
  input  wire             in_valid,  // Write request.
  output wire             in_ready,  // Room available.
  input  wire [WIDTH-1:0] in_data,   // Write data.
  output wire             out_valid, // Data available.
  input  wire             out_ready, // Read accept.
  output reg  [WIDTH-1:0] out_data   // Head word, combinational read.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @* begin
    out_data = mem[rd_q];
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // byte_fifo

//--- core/bit_rate_divider.v
module bit_rate_divider #(
  parameter DIV = 278
) (
  input  wire clock,    // System clock.
  input  wire nrst,     // Asynchronous reset, active low.
  input  wire bus_tick, // One-cycle bus clock enable.
  input  wire restart,  // Realigns the bit phase.
  output reg  bit_tick, // One-cycle pulse per bit time.
  output reg  half_tick // One-cycle pulse at mid bit.
);
  reg [8:0] cnt_q;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= 9'h000;
      bit_tick  <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      bit_tick  <= 1'b0;
      half_tick <= 1'b0;
      if (restart) begin
        cnt_q <= 9'h000;
      end else if (bus_tick) begin
        if (cnt_q == DIV - 1) begin
          cnt_q    <= 9'h000;
          bit_tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
        if (cnt_q == DIV / 2 - 1) begin
          half_tick <= 1'b1;
        end
      end
    end
  end
endmodule // bit_rate_divider

//--- core/monitor_mode_entry_control.v
// Behaviour
// RL1 - Mode is latched at reset release; later pin changes except serial pin are ignored (watchdog here still follows the test voltage pins).
// RL2 - Host holds serial high, a1 low, b0 high, b1 low, test voltage on irq.
// RL3 - Normal entry: divider pin low gives bus half input, high gives quarter.
// RL4 - Low divider pin with test voltage bypasses oscillator halving stage.
// RL5 - Blank reset vector allows entry without test voltage.
// RL6 - Forced entry ignores port B pins and divides clock by four.
// RL7 - Blank vector monitor entry performs one additional reset cycle.
// RL8 - Programmed vector permits entry only through test voltage.
// RL9 - Forced monitor disables watchdog unconditionally.
// RL10 - Normal entry keeps watchdog off while test voltage on irq or reset.
// RL11 - Host may move test voltage to reset pin, then free irq.
// RL12 - After reset, wait for eight security bytes before any command.
// RL13 - After security bytes, send break of ten zero bits.
// RL14 - Serial pin is wired-OR; only low is driven, pullup gives high.
// RL15 - Bit rate is bus frequency divided by 278.
// RL16 - Host commands may reach any address; code runs from RAM.
// RL17 - Received security bytes compared with stored bytes; match grants access.
// RL18 - NRZ mark/space framing with equal transmit and receive rates.
// RL19 - No entry condition means user mode, watchdog on, monitor idle.
`include "monitor_entry_regs.vh"
module monitor_mode_entry_control #(
  parameter BAUD_DIV = `BAUD_DIVISOR,
  parameter FIFO_DEPTH = 8
) (
  input  wire        clock,               // 40 MHz system clock.
  input  wire        nrst,                // Asynchronous reset, active low.
  input  wire        reset_pin_n,         // External reset pin level, low is reset.
  input  wire        irq_test_voltage,    // Test high voltage seen on irq pin.
  input  wire        rst_test_voltage,    // Test high voltage seen on reset pin.
  input  wire        mode_select_a1,      // Mode select pin a1.
  input  wire        mode_select_b0,      // Mode select pin b0.
  input  wire        mode_select_b1,      // Mode select pin b1.
  input  wire        clock_divider_select,// Divider select pin.
  input  wire        power_on_reset,      // Power-on reset pulse.
  input  wire        serial_in,           // Serial pin level.
  output wire        serial_out,          // Serial pin drive value, always low.
  output reg         serial_oe,           // Serial pin drive enable.
  output reg         monitor_mode,        // Monitor mode latched.
  output reg         forced_mode,         // Forced monitor entry.
  output reg  [1:0]  bus_div,             // Bus clock divide selection.
  output reg         osc_bypass,          // Oscillator halving stage bypassed.
  output reg         watchdog_enable,     // Watchdog timer enable.
  output reg         extra_reset,         // Request one additional reset cycle.
  output reg         flash_unlocked,      // Security bytes matched.
  input  wire [3:0]  avs_address,         // Avalon word address.
  input  wire        avs_read,            // Avalon read.
  input  wire        avs_write,           // Avalon write.
  input  wire [31:0] avs_writedata,       // Avalon write data.
  output reg  [31:0] avs_readdata,        // Avalon read data.
  output wire        avs_waitrequest      // Avalon wait request.
);
  // ========================================================================
  // Mode latch at the rising edge of the reset pin.
  localparam S_SEC   = 4'h1;
  localparam S_BREAK = 4'h2;
  localparam S_READY = 4'h4;
  localparam S_IDLE  = 4'h8;

  reg        rst_pin_q;
  reg        extra_done_q;
  reg [15:0] vector_q;
  reg        normal_q;
  wire       rst_rise;
  wire       serial_idle_ok;
  wire       vector_blank;
  wire       normal_entry;
  wire       forced_entry;

  assign rst_rise       = reset_pin_n && !rst_pin_q;
  assign serial_idle_ok = serial_in && !mode_select_a1;
  assign vector_blank   = (vector_q == `VECTOR_BLANK);
  assign normal_entry   = irq_test_voltage && serial_idle_ok &&
                          mode_select_b0 && !mode_select_b1;          // see RL2
  assign forced_entry   = !irq_test_voltage && vector_blank &&
                          serial_idle_ok;                             // see RL5 see RL8
  assign serial_out     = 1'b0;                                       // see RL14

  // The extra reset is asked once per power-on.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_pin_q       <= 1'b0;
      monitor_mode    <= 1'b0;
      forced_mode     <= 1'b0;
      normal_q        <= 1'b0;
      bus_div         <= `DIV_BY_FOUR;
      osc_bypass      <= 1'b0;
      extra_reset     <= 1'b0;
      extra_done_q    <= 1'b0;
    end else begin
      rst_pin_q   <= reset_pin_n;
      extra_reset <= 1'b0;
      if (power_on_reset) begin
        extra_done_q <= 1'b0;
      end

      if (rst_rise) begin                                              // see RL1
        monitor_mode <= normal_entry || forced_entry;                 // see RL19
        forced_mode  <= forced_entry && !normal_entry;
        normal_q     <= normal_entry;
        if (normal_entry) begin
          bus_div    <= clock_divider_select ? `DIV_BY_FOUR : `DIV_BY_TWO; // see RL3
          osc_bypass <= !clock_divider_select;                         // see RL4
        end else begin
          bus_div    <= `DIV_BY_FOUR;                                 // see RL6
          osc_bypass <= 1'b0;
        end
        if (forced_entry && !normal_entry && !extra_done_q) begin
          extra_reset  <= 1'b1;                                       // see RL7
          extra_done_q <= 1'b1;
        end
      end
    end
  end

  // In normal monitor mode the watchdog follows the test voltage pins live.
  always @* begin
    if (forced_mode) begin
      watchdog_enable = 1'b0;                                         // see RL9
    end else if (normal_q && monitor_mode) begin
      watchdog_enable = !(irq_test_voltage || rst_test_voltage);      // see RL10 see RL11
    end else begin
      watchdog_enable = 1'b1;                                         // see RL19
    end
  end

  // ========================================================================
  // Bus clock enable and bit timing.
  reg  [1:0] bus_cnt_q;
  reg        bus_tick;
  wire       bit_tick;
  wire       half_tick;
  reg        rx_restart;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_cnt_q <= 2'h0;
      bus_tick  <= 1'b0;
    end else begin
      bus_cnt_q <= bus_cnt_q + 2'h1;
      // The divide code picks which counts tick.
      case (bus_div)
        `DIV_BY_TWO:  bus_tick <= bus_cnt_q[0];
        `DIV_BY_FOUR: bus_tick <= (bus_cnt_q == 2'h3);
        default:      bus_tick <= 1'b1;
      endcase
    end
  end

  bit_rate_divider #(
    .DIV (BAUD_DIV)
  ) u_div (
    .clock     (clock),
    .nrst      (nrst),
    .bus_tick  (bus_tick),
    .restart   (rx_restart),
    .bit_tick  (bit_tick),
    .half_tick (half_tick)
  );                                                                  // see RL15

  // ========================================================================
  // Serial receiver, start bit, eight data bits, stop bit.
  reg [3:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg       rx_busy_q;
  reg       rx_push;
  reg [7:0] rx_byte_q;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_busy_q  <= 1'b0;
      rx_push    <= 1'b0;
      rx_byte_q  <= 8'h00;
      rx_restart <= 1'b0;
    end else begin
      rx_push    <= 1'b0;
      rx_restart <= 1'b0;
      if (!rx_busy_q) begin
        if (!serial_in && !serial_oe && monitor_mode) begin
          rx_busy_q  <= 1'b1;
          rx_bit_q   <= 4'h0;
          rx_restart <= 1'b1;
        end
      end else if (half_tick) begin                                   // see RL18
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && serial_in) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
          rx_sh_q <= {serial_in, rx_sh_q[7:1]};
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_byte_q <= rx_sh_q;
          // A low stop bit drops the byte.
          rx_push   <= serial_in;
        end
      end
    end
  end

  // ========================================================================
  // Received bytes, security check and break transmit.
  reg  [3:0]  state_q;
  reg  [3:0]  sec_cnt_q;
  reg         sec_ok_q;
  reg  [63:0] seckey_q;
  reg  [3:0]  brk_cnt_q;
  reg         fifo_pop;
  wire        fifo_ready;
  wire        fifo_valid;
  wire [7:0]  fifo_data;
  wire [7:0]  key_byte;

  // Key bytes are compared lowest first.
  assign key_byte = seckey_q[sec_cnt_q[2:0]*8 +: 8];

  // Bytes after the break queue here.
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (rx_push && state_q == S_READY),
    .in_ready  (fifo_ready),
    .in_data   (rx_byte_q),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q        <= S_IDLE;
      sec_cnt_q      <= 4'h0;
      sec_ok_q       <= 1'b1;
      brk_cnt_q      <= 4'h0;
      serial_oe      <= 1'b0;
      flash_unlocked <= 1'b0;
    end else begin
      if (power_on_reset) begin
        flash_unlocked <= 1'b0;
      end

      case (state_q)
        S_IDLE: begin
          serial_oe <= 1'b0;
        end

        S_SEC: begin
          if (rx_push) begin
            sec_cnt_q <= sec_cnt_q + 4'h1;
            if (rx_byte_q != key_byte) begin
              sec_ok_q <= 1'b0;                                       // see RL17
            end
            if (sec_cnt_q == `SEC_BYTES - 1) begin
              flash_unlocked <= flash_unlocked ||
                                (sec_ok_q && rx_byte_q == key_byte);
              state_q   <= S_BREAK;
              brk_cnt_q <= 4'h0;
            end
          end
        end

        S_BREAK: begin
          // Start on a bit edge so all bits are full.
          if (bit_tick && !serial_oe) begin
            serial_oe <= 1'b1;                                        // see RL13
          end
          if (bit_tick && serial_oe) begin
            brk_cnt_q <= brk_cnt_q + 4'h1;
            if (brk_cnt_q == `BREAK_BITS - 1) begin
              serial_oe <= 1'b0;
              state_q   <= S_READY;
            end
          end
        end

        S_READY: begin
          serial_oe <= 1'b0;                                          // see RL16
        end

        default: begin
          state_q <= S_IDLE;
        end
      endcase
      // Each reset release restarts the wait.
      if (rst_rise) begin
        serial_oe <= 1'b0;
        sec_cnt_q <= 4'h0;
        sec_ok_q  <= 1'b1;
        state_q   <= (normal_entry || forced_entry) ? S_SEC : S_IDLE;       // see RL12
      end
    end
  end

  // ========================================================================
  // Avalon slave, one cycle wait on reads so data come from a register.
  reg  rd_done_q;
  wire sel_rx;

  assign avs_waitrequest = avs_read && !rd_done_q;
  assign sel_rx          = (avs_address == `ADDR_RXDATA);

  always @* begin
    fifo_pop = avs_read && rd_done_q && sel_rx;
  end

  // Reads wait one cycle for registered data.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_done_q    <= 1'b0;
      avs_readdata <= 32'h00000000;
      seckey_q     <= 64'h0000000000000000;
      vector_q     <= `VECTOR_BLANK;
    end else begin
      rd_done_q <= avs_read && !rd_done_q;
      if (avs_read && !rd_done_q) begin
        case (avs_address)
          `ADDR_STATUS:    avs_readdata <= {22'h000000, bus_div,
                                            extra_done_q, fifo_valid,
                                            state_q == S_READY, flash_unlocked,
                                            state_q != S_SEC && monitor_mode,
                                            !watchdog_enable, forced_mode,
                                            monitor_mode};
          `ADDR_RXDATA:    avs_readdata <= {24'h000000, fifo_data};
          `ADDR_SECKEY_LO: avs_readdata <= seckey_q[31:0];
          `ADDR_SECKEY_HI: avs_readdata <= seckey_q[63:32];
          `ADDR_VECTOR:    avs_readdata <= {16'h0000, vector_q};
          default:         avs_readdata <= 32'h00000000;
        endcase
      end
      if (avs_write) begin
        case (avs_address)
          `ADDR_SECKEY_LO: seckey_q[31:0]  <= avs_writedata;
          `ADDR_SECKEY_HI: seckey_q[63:32] <= avs_writedata;
          `ADDR_VECTOR:    vector_q        <= avs_writedata[15:0];
          default:         vector_q        <= vector_q;
        endcase
      end
    end
  end
endmodule // monitor_mode_entry_control

//--- verification/monitor_mode_entry_control_sva.sv
module monitor_mode_entry_control_sva #(
  parameter int BAUD_DIV = 278
) (
  input logic       clock,                // System clock.
  input logic       nrst,                 // Reset, active low.
  input logic       reset_pin_n,          // Reset pin level.
  input logic       irq_test_voltage,     // Test voltage on irq.
  input logic       rst_test_voltage,     // Test voltage on reset pin.
  input logic       mode_select_a1,       // Strap a1.
  input logic       mode_select_b0,       // Strap b0.
  input logic       mode_select_b1,       // Strap b1.
  input logic       clock_divider_select, // Divider strap.
  input logic       power_on_reset,       // Power-on pulse.
  input logic       serial_in,            // Serial pin level.
  input logic       serial_out,           // Serial drive value.
  input logic       serial_oe,            // Serial drive enable.
  input logic       monitor_mode,         // Monitor latched.
  input logic       forced_mode,          // Forced entry.
  input logic [1:0] bus_div,              // Bus divide code.
  input logic       osc_bypass,           // Halving stage bypass.
  input logic       watchdog_enable,      // Watchdog enable.
  input logic       extra_reset,          // Extra reset pulse.
  input logic       avs_read,             // Bus read.
  input logic       avs_waitrequest       // Bus wait.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  localparam int BIT = 4 * BAUD_DIV;
  localparam int BLO = 19 * BIT / 2;
  localparam int BHI = 21 * BIT / 2;
  logic [15:0] run_q;
  logic [1:0]  ext_q;
  // ==========================================================================
  // Helper counters: length of the drive-low run, extra resets since power-on.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_q <= 16'h0000;
      ext_q <= 2'h0;
    end else begin
      run_q <= serial_oe ? run_q + 16'h0001 : 16'h0000;
      ext_q <= power_on_reset ? 2'h0 : ext_q + {1'b0, extra_reset & (ext_q != 2'h3)};
    end
  end
  // ==========================================================================
  // Properties.
  sequence normal_strap;
    irq_test_voltage && serial_in && !mode_select_a1 && mode_select_b0 && !mode_select_b1;
  endsequence
  sequence normal_latched;
    ##[1:2] (monitor_mode && !forced_mode && osc_bypass == !clock_divider_select
             && bus_div == (clock_divider_select ? 2'h2 : 2'h1));
  endsequence
  AST_NORMAL_ENTRY: assert property ($rose(reset_pin_n) ##0 normal_strap |-> normal_latched)
    else $error("normal entry divider wrong");
  AST_MODE_HOLD: assert property (reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 3)
    |-> $stable(monitor_mode) && $stable(forced_mode) && $stable(bus_div))
    else $error("mode changed after latch");
  AST_FORCED_DIV: assert property (forced_mode |-> bus_div == 2'h2 && !osc_bypass)
    else $error("forced entry divider wrong");
  AST_FORCED_WDOG: assert property (forced_mode |-> !watchdog_enable)
    else $error("watchdog on in forced mode");
  AST_NORMAL_WDOG: assert property (monitor_mode && (irq_test_voltage || rst_test_voltage)
    |-> !watchdog_enable)
    else $error("watchdog on under test voltage");
  AST_USER_WDOG: assert property (!monitor_mode |-> watchdog_enable)
    else $error("watchdog off in user mode");
  AST_BREAK_LEN: assert property ($fell(serial_oe) && bus_div == 2'h2
    |-> run_q >= BLO && run_q <= BHI)
    else $error("break length wrong");
  AST_DRIVE_LOW: assert property (serial_oe |-> serial_out == 1'b0 && monitor_mode)
    else $error("serial pin driven wrongly");
  AST_ONE_EXTRA: assert property (extra_reset && !power_on_reset |-> ext_q == 2'h0 ##1 !extra_reset)
    else $error("extra reset repeated");
  AST_READ_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing wrong");
endmodule // monitor_mode_entry_control_sva
bind monitor_mode_entry_control monitor_mode_entry_control_sva #(.BAUD_DIV(BAUD_DIV)) sva (
  .clock, .nrst, .reset_pin_n, .irq_test_voltage, .rst_test_voltage, .mode_select_a1,
  .mode_select_b0, .mode_select_b1, .clock_divider_select, .power_on_reset, .serial_in,
  .serial_out, .serial_oe, .monitor_mode, .forced_mode, .bus_div, .osc_bypass,
  .watchdog_enable, .extra_reset, .avs_read, .avs_waitrequest
);

//--- verification/host_link_model.sv
module host_link_model #(
  parameter int BIT = 32
) (
  input  logic clock,    // System clock.
  input  logic line,     // Resolved serial pin.
  output logic drive_low // High while pulling the pin low.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial drive_low = 1'b0;
  // Idles for gap cycles, then sends start bit, eight bits lowest first, stop bit.
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clock);
    repeat (gap) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      drive_low <= !f[i];
      repeat (BIT) @(posedge clock);
    end
  endtask
  // Waits for the device to pull the pin low and counts how long it stays low.
  task automatic wait_break(output int len);
    int n;
    n = 0;
    len = 0;
    while (line !== 1'b0 && n < 40 * BIT) begin
      @(posedge clock);
      n++;
    end
    while (line === 1'b0 && len < 20 * BIT) begin
      @(posedge clock);
      len++;
    end
  endtask
endmodule // host_link_model

//--- verification/tb_top.sv
`include "monitor_entry_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BDIV = 8;
  localparam int BIT  = 4 * BDIV;
  localparam logic [63:0] KEY = 64'h8877665544332211;
  typedef struct packed {
    logic tv, vb, a1, b0, ds, mon, frc, byp, wd;
    logic [1:0] div;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1},
    '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2},
    '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2},
    '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0},
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0},
    '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2}};
  logic        clock, nrst, reset_pin_n, irq_test_voltage, rst_test_voltage;
  logic        mode_select_a1, mode_select_b0, mode_select_b1, clock_divider_select;
  logic        power_on_reset, avs_read, avs_write, drive_low;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, d;
  wire  [31:0] avs_readdata;
  wire         serial_in, serial_out, serial_oe, monitor_mode, forced_mode, osc_bypass;
  wire         watchdog_enable, extra_reset, flash_unlocked, avs_waitrequest;
  wire  [1:0]  bus_div;
  int          fail_count = 0, checks = 0, ext_n = 0, len;
  row_t        r;
  assign serial_in = !(drive_low || serial_oe);
  monitor_mode_entry_control #(.BAUD_DIV(BDIV)) dut (
    .clock, .nrst, .reset_pin_n, .irq_test_voltage, .rst_test_voltage, .mode_select_a1,
    .mode_select_b0, .mode_select_b1, .clock_divider_select, .power_on_reset, .serial_in,
    .serial_out, .serial_oe, .monitor_mode, .forced_mode, .bus_div, .osc_bypass,
    .watchdog_enable, .extra_reset, .flash_unlocked, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest
  );
  host_link_model #(.BIT(BIT)) host (.clock, .line(serial_in), .drive_low);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) if (extra_reset === 1'b1) ext_n <= ext_n + 1;
  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 64) check(1'b0, 1'b1);
  endtask
  task automatic enter(input logic tv, input logic vb, input logic a1, input logic b0,
                       input logic ds);
    bus(1'b1, `ADDR_VECTOR, vb ? 32'h0000ffff : 32'h00001234);
    reset_pin_n <= 1'b0;
    irq_test_voltage <= tv;
    rst_test_voltage <= 1'b0;
    mode_select_a1 <= a1;
    mode_select_b0 <= b0;
    mode_select_b1 <= 1'b0;
    clock_divider_select <= ds;
    step(4);
    reset_pin_n <= 1'b1;
    step(4);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    step(60000);
    fail_count++;
    tally_and_finish();
  end
  // ==========================================================================
  // Tests.
  initial begin
    {nrst, reset_pin_n, irq_test_voltage, rst_test_voltage, mode_select_a1} = '0;
    {mode_select_b0, mode_select_b1, clock_divider_select, power_on_reset} = '0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    step(8);
    nrst <= 1'b1;
    step(1);
    check({monitor_mode, forced_mode, serial_oe, watchdog_enable, bus_div}, 6'h06);
    bus(1'b0, 4'hf, 32'h0);
    check(d, 32'h0);
    $display("Reset test done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      enter(r.tv, r.vb, r.a1, r.b0, r.ds);
      for (int k = 0; k < 2; k++) begin
        check({monitor_mode, forced_mode, watchdog_enable}, {r.mon, r.frc, r.wd});
        if (r.mon) check({bus_div, osc_bypass}, {r.div, r.byp});
        {mode_select_a1, mode_select_b0, mode_select_b1, clock_divider_select} <= 4'hf;
        step(3);
      end
      bus(1'b0, `ADDR_STATUS, 32'h0);
      check(d[2:0], {!r.wd, r.frc, r.mon});
      $display("Row %0d done", i);
    end
    enter(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    rst_test_voltage <= 1'b1;
    step(2);
    irq_test_voltage <= 1'b0;
    step(2);
    check(watchdog_enable, 1'b0);
    rst_test_voltage <= 1'b0;
    step(2);
    check(watchdog_enable, 1'b1);
    enter(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    irq_test_voltage <= 1'b1;
    rst_test_voltage <= 1'b1;
    step(2);
    check({forced_mode, watchdog_enable}, 2'h2);
    $display("Watchdog test done");
    power_on_reset <= 1'b1;
    step(2);
    power_on_reset <= 1'b0;
    bus(1'b1, `ADDR_SECKEY_LO, KEY[31:0]);
    bus(1'b1, `ADDR_SECKEY_HI, KEY[63:32]);
    len = ext_n;
    enter(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    step(4);
    check(ext_n - len, 32'h1);
    for (int k = 0; k < 7; k++) host.send(KEY[8*k +: 8], k * BIT);
    step(4 * BIT);
    check(serial_oe, 1'b0);
    host.send(KEY[63:56], 0);
    host.wait_break(len);
    check(len >= 19 * BIT / 2 && len <= 21 * BIT / 2, 1'b1);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    check({d[5:3], flash_unlocked}, 4'hf);
    $display("Link test done");
    for (int k = 0; k < 9; k++) host.send(8'ha0 + k[7:0], k == 4 ? 8 * BIT : 0);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    check(d[6], 1'b1);
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, `ADDR_RXDATA, 32'h0);
      check(d[7:0], 8'ha0 + k[7:0]);
    end
    bus(1'b0, `ADDR_STATUS, 32'h0);
    check(d[6], 1'b0);
    len = ext_n;
    enter(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    check({ext_n[30:0] - len[30:0], flash_unlocked}, 32'h1);
    $display("Buffer test done");
    tally_and_finish();
  end
endmodule // tb_top
